/* File: hdl/dcc_route.sv */
// Asynchronous polarity and output routing of one comparator
`timescale 1ns/100ps
`default_nettype none
module dcc_route (
  input wire logic raw_out,
  input wire logic invert,
  input wire logic enable,
  input wire logic [2:0] route,
  output logic pin_out,
  output logic [6:0] timer_sel,
  output logic event_line
);
  logic pol;
  // Pure gates, no clock: outputs stay valid while the bus clock is stopped
  assign pol = enable & (raw_out ^ invert);
  assign pin_out = pol;
  assign event_line = pol;
  // Code 000 drives nothing; code n drives destination n-1
  genvar i;
  generate
    for (i = 0; i < 7; i++) begin : g_sel
      assign timer_sel[i] = pol & (route == 3'(i + 1));
    end
  endgenerate
endmodule // dcc_route
`default_nettype wire

/* File: hdl/dcc_top.sv */
// Dual comparator control: register file, locks, routing and interrupts
//
// Overview of operation
// - Two comparators, each with own configuration half, output and routing.
// - Each inverting input selects pins, converter output, reference or fractions.
// - Two-bit hysteresis field per comparator, code 00 means none.
// - Two-bit speed field: 00 fast, 01 medium, 10 low, 11 ultra-low.
// - Outputs route to a pin or timer capture, reference-clear or break.
// - Pin output and a timer destination can be driven at once.
// - Window bit ties second comparator's non-inverting input to the first.
// - Registers run on the bus clock with no private clock enable.
// - Only system reset returns the configuration to its defaults.
// - Polarity and pin routing are combinational, working without bus clock.
// - Lock bit makes the comparator's configuration half read-only, lock included.
// - Lock stays set until reset; no write clears it.
// - Each output drives its own event line to the event controller.
// - Bit 31 locks bits 31:16, bit 15 locks bits 15:0.
// - Polarity bit 1 inverts output, 0 passes it unchanged.
// - Read-only status bit per comparator shows the synchronised raw comparator level, ignoring polarity and enable.
// - Three-bit route field picks timer destination; 000 routes nowhere.
`timescale 1ns/100ps
`default_nettype none
`include "dcc_defines.svh"
module dcc_top (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic comparator_a_raw,
  input wire logic comparator_b_raw,
  output logic [15:0] comparator_a_cfg,
  output logic [15:0] comparator_b_cfg,
  output logic window_enable,
  output logic comparator_a_pin,
  output logic comparator_b_pin,
  output logic [6:0] comparator_a_timer_sel,
  output logic [6:0] comparator_b_timer_sel,
  output logic comparator_a_event,
  output logic comparator_b_event,
  output logic irq
);
  dcc_pkg::dcc_state_type s_q;
  dcc_pkg::dcc_state_type s_d;
  logic [1:0] sync1_q;
  logic [1:0] sync2_q;
  logic [2:0] warm_q;

  // Two-flop synchronisers for the asynchronous comparator outputs
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync1_q <= 2'h0;
      sync2_q <= 2'h0;
      warm_q <= 3'h0;
    end else begin
      sync1_q <= {comparator_b_raw, comparator_a_raw};
      sync2_q <= sync1_q;
      warm_q <= {warm_q[1:0], 1'b1};
    end
  end

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return (a == `DCC_CSR_OFFSET) || (a == `DCC_IRQ_STATUS_OFFSET) ||
           (a == `DCC_IRQ_MASK_OFFSET);
  endfunction

  logic [31:0] csr_view;
  logic [31:0] wv;
  logic [31:0] keep;
  logic [1:0] edge_ev;
  logic [7:0] waddr;
  logic [31:0] wdat;
  logic [3:0] wstb;

  always_comb begin
    s_d = s_q;
    wv = 32'h0;
    keep = 32'h0;
    waddr = s_q.awaddr;
    wdat = s_q.wdata;
    wstb = s_q.wstrb;
    csr_view = s_q.csr;
    csr_view[`DCC_A_OUT_BIT] = sync2_q[0];
    csr_view[`DCC_B_OUT_BIT] = sync2_q[1];
    // Any change of a synchronised output is an event
    // Held off until the history holds real levels, else a high output
    // would fake an edge right after reset
    edge_ev = (sync2_q ^ s_q.out_prev) & {2{warm_q[2]}};
    s_d.out_prev = sync2_q;
    s_d.awready = 1'b0;
    s_d.wready = 1'b0;
    s_d.arready = 1'b0;
    unique case (s_q.st)
      dcc_pkg::DCC_IDLE: begin
        if (s_axi_awvalid && !s_q.aw_seen && !s_q.awready) begin
          s_d.awready = 1'b1;
          s_d.aw_seen = 1'b1;
          s_d.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !s_q.w_seen && !s_q.wready) begin
          s_d.wready = 1'b1;
          s_d.w_seen = 1'b1;
          s_d.wdata = s_axi_wdata;
          s_d.wstrb = s_axi_wstrb;
        end
        if (s_q.aw_seen && s_q.w_seen) begin
          s_d.aw_seen = 1'b0;
          s_d.w_seen = 1'b0;
          s_d.bvalid = 1'b1;
          s_d.resp = mapped(waddr) ? 2'h0 : 2'h2;
          s_d.st = dcc_pkg::DCC_WRESP;
          if (waddr == `DCC_CSR_OFFSET) begin
            wv = merge(s_q.csr, wdat, wstb);
            // Locked halves keep their value; lock itself is sticky
            keep = {{16{s_q.csr[`DCC_B_LOCK_BIT]}},
                    {16{s_q.csr[`DCC_A_LOCK_BIT]}}};
            s_d.csr = ((s_q.csr & keep) | (wv & ~keep)) & `DCC_CSR_RW_MASK;
            s_d.csr[`DCC_B_LOCK_BIT] = s_q.csr[`DCC_B_LOCK_BIT] |
                                       wv[`DCC_B_LOCK_BIT];
            s_d.csr[`DCC_A_LOCK_BIT] = s_q.csr[`DCC_A_LOCK_BIT] |
                                       wv[`DCC_A_LOCK_BIT];
          end
          if (waddr == `DCC_IRQ_MASK_OFFSET && wstb[0]) begin
            s_d.irq_mask = wdat[1:0];
          end
          if (waddr == `DCC_IRQ_STATUS_OFFSET && wstb[0]) begin
            s_d.irq_status = s_q.irq_status & ~wdat[1:0];
          end
        end else if (s_axi_arvalid && !s_q.arready) begin
          s_d.arready = 1'b1;
          s_d.st = dcc_pkg::DCC_RDATA;
          s_d.resp = mapped(s_axi_araddr) ? 2'h0 : 2'h2;
          if (s_axi_araddr == `DCC_CSR_OFFSET) begin
            s_d.rdata = csr_view;
          end else if (s_axi_araddr == `DCC_IRQ_STATUS_OFFSET) begin
            s_d.rdata = {30'h0, s_q.irq_status};
          end else if (s_axi_araddr == `DCC_IRQ_MASK_OFFSET) begin
            s_d.rdata = {30'h0, s_q.irq_mask};
          end else begin
            s_d.rdata = 32'h0;
          end
        end
      end
      dcc_pkg::DCC_WRESP: begin
        if (s_axi_bready) begin
          s_d.bvalid = 1'b0;
          s_d.st = dcc_pkg::DCC_IDLE;
        end
      end
      dcc_pkg::DCC_RDATA: begin
        // Data is offered only after the address handshake has completed
        if (!s_q.rvalid) begin
          s_d.rvalid = 1'b1;
        end else if (s_axi_rready) begin
          s_d.rvalid = 1'b0;
          s_d.st = dcc_pkg::DCC_IDLE;
        end
      end
      default: begin
        s_d.st = dcc_pkg::DCC_IDLE;
      end
    endcase
    // A new event wins over a clear in the same cycle
    s_d.irq_status = s_d.irq_status | edge_ev;
    s_d.irq = |(s_d.irq_status & s_d.irq_mask);
  end

  // Only the system reset clears the configuration
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_q <= '{st: dcc_pkg::DCC_IDLE, csr: `DCC_CSR_RESET, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign s_axi_awready = s_q.awready;
  assign s_axi_wready = s_q.wready;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.resp;
  assign s_axi_arready = s_q.arready;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.resp;
  assign irq = s_q.irq;
  // Analog settings: hysteresis, speed, input select, enables
  assign comparator_a_cfg = s_q.csr[15:0];
  assign comparator_b_cfg = s_q.csr[31:16];
  assign window_enable = s_q.csr[23];

  // Routing is gates only, so it bypasses the register clock
  dcc_route u_route_a (
    .raw_out(comparator_a_raw),
    .invert(s_q.csr[11]),
    .enable(s_q.csr[0]),
    .route(s_q.csr[10:8]),
    .pin_out(comparator_a_pin),
    .timer_sel(comparator_a_timer_sel),
    .event_line(comparator_a_event)
  );
  dcc_route u_route_b (
    .raw_out(comparator_b_raw),
    .invert(s_q.csr[27]),
    .enable(s_q.csr[16]),
    .route(s_q.csr[26:24]),
    .pin_out(comparator_b_pin),
    .timer_sel(comparator_b_timer_sel),
    .event_line(comparator_b_event)
  );
endmodule // dcc_top
`default_nettype wire

/* File: include/dcc_defines.svh */
// Offsets, field positions, reset values and timing counts of the comparator control
`ifndef DCC_DEFINES_SVH
`define DCC_DEFINES_SVH
`define DCC_CSR_OFFSET 8'h1c
`define DCC_IRQ_STATUS_OFFSET 8'h20
`define DCC_IRQ_MASK_OFFSET 8'h24
`define DCC_CSR_RESET 32'h0000_0000
`define DCC_B_LOCK_BIT 31
`define DCC_B_OUT_BIT 30
`define DCC_A_LOCK_BIT 15
`define DCC_A_OUT_BIT 14
`define DCC_CSR_RW_MASK 32'hbffd_bf7f
`define DCC_SYNC_STAGES 2
`endif

/* File: include/dcc_pkg.sv */
// Types of the comparator control block
package dcc_pkg;
  typedef struct packed {
    logic lock;
    logic [1:0] hyst;
    logic invert;
    logic [2:0] route;
    logic aux;
    logic [2:0] insel;
    logic [1:0] speed;
    logic inp_sw;
    logic enable;
  } dcc_cfg_type;
  typedef struct packed {
    logic [4:0] pin_out;
    logic [4:0] pin_oe;
  } dcc_unused_type;
  typedef struct packed {
    logic capture;
    logic ref_clear;
    logic brk;
    logic capture2;
    logic ref_clear2;
    logic brk_unused;
  } dcc_unused2_type;
  typedef struct packed {
    logic [6:0] sel;
  } dcc_route_type;
  typedef enum logic [1:0] {
    DCC_IDLE,
    DCC_WRESP,
    DCC_RDATA
  } dcc_bus_state_type;
  typedef struct packed {
    dcc_bus_state_type st;
    logic [31:0] csr;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    logic [1:0] out_prev;
    logic aw_seen;
    logic w_seen;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] resp;
    logic irq;
  } dcc_state_type;
endpackage

/* File: verif/dcc_far_model.sv */
// Far side: comparator sources and the event controller line
`timescale 1ns/100ps
`default_nettype none
module dcc_far_model (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic lvl_a,
  input wire logic lvl_b,
  input wire logic comparator_a_event,
  output logic comparator_a_raw = 1'h0,
  output logic comparator_b_raw = 1'h0,
  output logic [7:0] ev_cnt
);
  logic ev_q;
  // Decisions move on the clock so the bench can reason in cycles
  always @(posedge core_clk) begin
    comparator_a_raw <= lvl_a;
    comparator_b_raw <= lvl_b;
  end
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ev_q <= 1'h0;
      ev_cnt <= 8'h00;
    end else begin
      ev_q <= comparator_a_event;
      if (ev_q != comparator_a_event) ev_cnt <= ev_cnt + 8'h01;
    end
  end
endmodule // dcc_far_model
`default_nettype wire

/* File: verif/dcc_props.sv */
// Port checker of the comparator control block
`timescale 1ns/100ps
`default_nettype none
module dcc_props (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic comparator_a_raw,
  input wire logic comparator_b_raw,
  input wire logic [15:0] comparator_a_cfg,
  input wire logic [15:0] comparator_b_cfg,
  input wire logic window_enable,
  input wire logic comparator_a_pin,
  input wire logic comparator_b_pin,
  input wire logic [6:0] comparator_a_timer_sel,
  input wire logic [6:0] comparator_b_timer_sel,
  input wire logic comparator_a_event,
  input wire logic comparator_b_event
);
  logic [15:0] ca, cb;
  assign ca = comparator_a_cfg;
  assign cb = comparator_b_cfg;
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  property p_pin_a;
    comparator_a_pin == (ca[0] & (comparator_a_raw ^ ca[11]));
  endproperty
  a_pin_a: assert property (p_pin_a) else $error("pin a");
  property p_pin_b;
    comparator_b_pin == (cb[0] & (comparator_b_raw ^ cb[11]));
  endproperty
  a_pin_b: assert property (p_pin_b) else $error("pin b");
  property p_sel_a;
    comparator_a_timer_sel == (ca[10:8] == 3'h0 ? 7'h00 :
      7'(comparator_a_pin) << (ca[10:8] - 3'h1));
  endproperty
  a_sel_a: assert property (p_sel_a) else $error("route a");
  property p_sel_b;
    comparator_b_timer_sel == (cb[10:8] == 3'h0 ? 7'h00 :
      7'(comparator_b_pin) << (cb[10:8] - 3'h1));
  endproperty
  a_sel_b: assert property (p_sel_b) else $error("route b");
  property p_event;
    comparator_a_event == comparator_a_pin &&
      comparator_b_event == comparator_b_pin;
  endproperty
  a_event: assert property (p_event) else $error("event line");
  property p_lock_a;
    ca[15] |=> $stable(ca);
  endproperty
  a_lock_a: assert property (p_lock_a) else $error("lock a");
  property p_lock_b;
    cb[15] |=> $stable(cb);
  endproperty
  a_lock_b: assert property (p_lock_b) else $error("lock b");
  property p_win;
    window_enable == cb[7];
  endproperty
  a_win: assert property (p_win) else $error("window");
  c_lock: cover property ($rose(cb[15]));
  c_sel: cover property (comparator_a_timer_sel[6]);
  c_win: cover property (window_enable && comparator_b_pin);
endmodule // dcc_props
bind dcc_top dcc_props u_props (.core_clk, .sys_rst, .comparator_a_raw,
  .comparator_b_raw, .comparator_a_cfg, .comparator_b_cfg, .window_enable,
  .comparator_a_pin, .comparator_b_pin, .comparator_a_timer_sel,
  .comparator_b_timer_sel, .comparator_a_event, .comparator_b_event);
`default_nettype wire

/* File: verif/testbench.sv */
// Self-checking bench of the comparator control block
`timescale 1ns/100ps
`default_nettype none
`include "dcc_defines.svh"
module testbench;
  logic core_clk = 1'h0, sys_rst = 1'h1, lvl_a = 1'h0, lvl_b = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, ev_cnt;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d, e, q;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, comparator_a_raw, comparator_b_raw, window_enable;
  logic comparator_a_pin, comparator_b_pin, comparator_a_event;
  logic comparator_b_event, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [15:0] comparator_a_cfg, comparator_b_cfg, h;
  logic [6:0] comparator_a_timer_sel, comparator_b_timer_sel;
  int mismatches = 0, num_checks = 0;
  dcc_top uut (.core_clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .comparator_a_raw, .comparator_b_raw, .comparator_a_cfg, .comparator_b_cfg,
    .window_enable, .comparator_a_pin, .comparator_b_pin, .irq,
    .comparator_a_timer_sel, .comparator_b_timer_sel, .comparator_a_event,
    .comparator_b_event);
  dcc_far_model far (.core_clk, .sys_rst, .lvl_a, .lvl_b, .comparator_a_event,
    .comparator_a_raw, .comparator_b_raw, .ev_cnt);
  initial forever #20 core_clk = ~core_clk;
  task automatic chk(input string n, input logic [31:0] ex, got);
    num_checks++;
    if (got !== ex) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, ex, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'h0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1);
    v = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'h0;
    @(posedge core_clk);
  endtask
  // Status bits read the synchronised raw levels, not the polarity output
  function automatic logic [31:0] exp_csr(input logic [31:0] v);
    return (v & `DCC_CSR_RW_MASK) | {1'h0, lvl_b, 15'h0, lvl_a, 14'h0};
  endfunction
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    #200000;
    mismatches++;
    test_done();
  end
  initial begin
    e = $urandom(44090);
    repeat (8) @(posedge core_clk);
    sys_rst <= 1'h0;
    @(posedge core_clk);
    rd(8'h1c, q);
    chk("csr reset", 32'h0, q);
    for (int i = 0; i < 8; i++) begin
      e = $urandom;
      h = {2'h0, i[1:0], e[0], i[2:0], e[1], i[2:0], i[1:0], e[2], 1'h1};
      d = {h, h};
      lvl_a <= e[3];
      lvl_b <= e[4];
      wr(8'h1c, d);
      chk("cfg", d & `DCC_CSR_RW_MASK, {comparator_b_cfg, comparator_a_cfg});
      chk("window", {31'h0, d[23]}, {31'h0, window_enable});
      rd(8'h1c, q);
      chk("csr", exp_csr(d), q);
    end
    $display("test config done");
    rd(8'h40, q);
    chk("rresp", 32'h2, {30'h0, rsp});
    chk("rdata", 32'h0, q);
    wr(8'h40, 32'hffff_ffff);
    chk("bresp", 32'h2, {30'h0, rsp});
    $display("test unmapped done");
    wr(8'h24, 32'h1);
    wr(8'h20, 32'h3);
    e = {24'h0, ev_cnt};
    lvl_a <= ~lvl_a;
    lvl_b <= ~lvl_b;
    repeat (6) @(posedge core_clk);
    chk("irq set", 32'h1, {31'h0, irq});
    chk("events", e + 32'h1, {24'h0, ev_cnt});
    rd(8'h20, q);
    chk("status", 32'h3, q);
    wr(8'h20, 32'h1);
    repeat (2) @(posedge core_clk);
    chk("irq masked", 32'h0, {31'h0, irq});
    rd(8'h20, q);
    chk("status left", 32'h2, q);
    $display("test irq done");
    wr(8'h1c, 32'h0000_8a5d);
    wr(8'h1c, 32'h5a5a_7fff);
    rd(8'h1c, q);
    chk("lock a", exp_csr(32'h5a5a_8a5d), q);
    wr(8'h1c, 32'h8000_0000);
    wr(8'h1c, 32'h0);
    rd(8'h1c, q);
    chk("lock both", exp_csr(32'h8000_8a5d), q);
    sys_rst <= 1'h1;
    lvl_a <= 1'h1;
    lvl_b <= 1'h1;
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'h0;
    repeat (3) @(posedge core_clk);
    rd(8'h1c, q);
    chk("csr rerun", exp_csr(32'h0), q);
    rd(8'h20, q);
    chk("status rerun", 32'h0, q);
    $display("test lock done");
    test_done();
  end
endmodule // testbench
`default_nettype wire
